/* File: src/dsq_pkg.sv */
// Constants and types shared by the deep sleep sequencer
package dsq_pkg;

  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned MS_PER_SEC    = 1000;
  localparam int unsigned SEC_PER_MIN   = 60;
  localparam int unsigned WAKE_DLY_MS   = 16;
  localparam int unsigned PULSE_MS      = 32;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONFIG     = 8'h30;
  localparam logic [7:0] IDX_STATUS     = 8'h31;
  localparam logic [7:0] IDX_WAKE_DELAY = 8'he0;
  localparam logic [7:0] IDX_WAKE_WIDTH = 8'he1;
  localparam logic [7:0] IDX_ENTRY_DLY  = 8'he2;

  // Reset values
  localparam logic [7:0] RST_CONFIG     = 8'h20;
  localparam logic [7:0] RST_WAKE_DELAY = 8'h20;
  localparam logic [7:0] RST_WAKE_WIDTH = 8'h04;
  localparam logic [7:0] RST_ENTRY_DLY  = 8'h05;

  // Writable bit masks
  localparam logic [7:0] MSK_CONFIG     = 8'hdb;
  localparam logic [7:0] MSK_WAKE_DELAY = 8'h3f;
  localparam logic [7:0] MSK_WAKE_WIDTH = 8'h0f;
  localparam logic [7:0] MSK_ENTRY_DLY  = 8'hff;

  // Configuration bit positions
  localparam int unsigned CFG_DEEP_S5   = 0;
  localparam int unsigned CFG_DEEP_S3   = 1;
  localparam int unsigned CFG_DEEP_WELL = 3;
  localparam int unsigned CFG_WAKE_OPT  = 4;
  localparam int unsigned CFG_RR_SRC    = 6;
  localparam int unsigned CFG_PU_DIS    = 7;

  // Entry delay, wake delay and pulse width fields
  localparam int unsigned ENTRY_UNIT    = 7;
  localparam int unsigned ENTRY_CNT_MSB = 6;
  localparam int unsigned WAKE_DLY_MSB  = 5;
  localparam int unsigned WIDTH_MSB     = 3;

  localparam int unsigned CNT_W = 10;

  typedef enum logic [2:0] {
    DSQ_RUN        = 3'b000,
    DSQ_ENTRY_WAIT = 3'b001,
    DSQ_DEEP       = 3'b010,
    DSQ_WAKE_RAIL  = 3'b011,
    DSQ_WAKE_DELAY = 3'b100,
    DSQ_WAKE_PULSE = 3'b101,
    DSQ_WAKE_HOLD  = 3'b110
  } dsq_state_t;

endpackage : dsq_pkg

/* File: src/dsq_tick_if.sv */
// Time base ticks carried from the time base to the sequencer
`timescale 1ns/100ps
interface dsq_tick_if;
  logic ms_tick;
  logic sec_tick;
  logic min_tick;

  modport src (output ms_tick, output sec_tick, output min_tick);
  modport snk (input ms_tick, input sec_tick, input min_tick);
endinterface : dsq_tick_if

/* File: src/dsq_timebase.sv */
// Free-running millisecond, second and minute tick generator
`timescale 1ns/100ps
module dsq_timebase
  import dsq_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = MS_CYCLES
)(
  input  wire logic clk,
  input  wire logic reset,
  dsq_tick_if.src   tick
);

  logic [17:0] cyc_r;
  logic [9:0]  ms_r;
  logic [5:0]  sec_r;
  logic        ms_r_tick;
  logic        sec_r_tick;
  logic        min_r_tick;

  // Cycle prescaler
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cyc_r     <= '0;
      ms_r_tick <= 1'b0;
    end
    else
    begin
      ms_r_tick <= 1'b0;
      if (cyc_r == 18'(CYC_PER_MS - 1))
      begin
        cyc_r     <= '0;
        ms_r_tick <= 1'b1;
      end
      else
        cyc_r <= cyc_r + 18'h1;
    end
  end

  // Millisecond to second
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ms_r       <= '0;
      sec_r_tick <= 1'b0;
    end
    else
    begin
      sec_r_tick <= 1'b0;
      if (ms_r_tick)
      begin
        if (ms_r == 10'(MS_PER_SEC - 1))
        begin
          ms_r       <= '0;
          sec_r_tick <= 1'b1;
        end
        else
          ms_r <= ms_r + 10'h1;
      end
    end
  end

  // Second to minute
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sec_r      <= '0;
      min_r_tick <= 1'b0;
    end
    else
    begin
      min_r_tick <= 1'b0;
      if (sec_r_tick)
      begin
        if (sec_r == 6'(SEC_PER_MIN - 1))
        begin
          sec_r      <= '0;
          min_r_tick <= 1'b1;
        end
        else
          sec_r <= sec_r + 6'h1;
      end
    end
  end

  assign tick.ms_tick  = ms_r_tick;
  assign tick.sec_tick = sec_r_tick;
  assign tick.min_tick = min_r_tick;

endmodule : dsq_timebase

/* File: src/dsq_delay_cnt.sv */
// Loadable down counter paced by a tick enable
`timescale 1ns/100ps
module dsq_delay_cnt
  import dsq_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] count,
  input  wire logic             tick,
  output logic                  done
);

  logic [CNT_W-1:0] cnt_r;
  logic             busy_r;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
    end
    else if (load)
    begin
      cnt_r  <= count;
      busy_r <= 1'b1;
    end
    else if (busy_r && cnt_r == '0)
      busy_r <= 1'b0;
    else if (busy_r && tick)
      cnt_r <= cnt_r - CNT_W'(1);
  end

  assign done = busy_r && (cnt_r == '0);

endmodule : dsq_delay_cnt

/* File: src/dsq_top.sv */
// Deep sleep power sequencer with Avalon-MM register slave
`timescale 1ns/100ps
// Contract
// RULE_01 - Deep S5 enable bit lets S5 entry start deep sleep; off when clear. Code also enters on S5 entry when the deep S3 enable is set.
// RULE_02 - Deep S3 enable bit lets S3 entry start deep sleep; off when clear.
// RULE_03 - Deep-well enable lets suspend sleep level hold resume reset low.
// RULE_04 - After deep S5 wake, hold power switch low per wake release option.
// RULE_05 - Release option counts only with deep-well and a deep sleep enable.
// RULE_06 - Detect source zero: resume reset release follows power switch level.
// RULE_07 - Software clears detect source for deep S5, sets it for deep-well.
// RULE_08 - Pull-up disable bit turns off suspend sleep input pull-up.
// RULE_09 - Wake waits standby rail, then wake delay, then drives the low pulse.
// RULE_10 - Wake delay is six-bit field times 16 ms.
// RULE_11 - Low pulse width is four-bit field times 32 ms.
// RULE_12 - Leaving S0 waits the seven-bit entry delay before deep sleep.
// RULE_13 - Entry delay unit is seconds when bit 7 clear, minutes when set.
// RULE_14 - Configuration register resets to 20h only on battery reset.
// RULE_15 - Delays count from a free-running standby time base.
module dsq_top
  import dsq_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = MS_CYCLES
)(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        sleep_s3_n,
  input  wire logic        sleep_s5_n,
  input  wire logic        suspend_sleep_n,
  input  wire logic        standby_rail_good,
  input  wire logic        wake_event,
  output logic             power_switch_out_n,
  output logic             resume_reset_n,
  output logic             suspend_pullup_en,
  output logic             deep_sleep_active
);

  dsq_tick_if tick ();

  dsq_state_t        state_r;
  logic [7:0]        config_r;
  logic [7:0]        wake_delay_r;
  logic [7:0]        wake_width_r;
  logic [7:0]        entry_dly_r;
  logic [31:0]       readdata_r;
  logic              waitreq_r;
  logic              psw_n_r;
  logic              rr_n_r;
  logic              pu_en_r;
  logic              deep_r;
  logic              s5_wake_r;
  logic              pulsed_r;
  logic [3:0]        meta_r;
  logic [3:0]        sync_r;
  logic              s3_n_s;
  logic              s5_n_s;
  logic              sus_n_s;
  logic              rail_s;
  logic [1:0]        wake_meta_r;
  logic              wake_s;
  logic              cnt_load;
  logic [CNT_W-1:0]  cnt_value;
  logic              cnt_tick;
  logic              cnt_done;
  logic              opt_on;
  logic              enter_s5;
  logic              enter_s3;
  logic              hold_done;
  logic              rr_release;
  logic              wr_take;
  logic              rd_take;
  logic [7:0]        reg_idx;
  logic [7:0]        rd_byte;

  dsq_timebase #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_timebase (
    .clk   (clk),
    .reset (reset),
    .tick  (tick.src)
  );

  dsq_delay_cnt u_delay (
    .clk   (clk),
    .reset (reset),
    .load  (cnt_load),
    .count (cnt_value),
    .tick  (cnt_tick),
    .done  (cnt_done)
  );

  // Two-stage synchronisers for pins
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      meta_r      <= 4'hf;
      sync_r      <= 4'hf;
      wake_meta_r <= 2'h0;
    end
    else
    begin
      meta_r      <= {sleep_s3_n, sleep_s5_n, suspend_sleep_n, standby_rail_good};
      sync_r      <= meta_r;
      wake_meta_r <= {wake_meta_r[0], wake_event};
    end
  end

  assign s3_n_s  = sync_r[3];
  assign s5_n_s  = sync_r[2];
  assign sus_n_s = sync_r[1];
  assign rail_s  = sync_r[0];
  assign wake_s  = wake_meta_r[1];

  // Bus decode
  assign reg_idx = avs_address[9:2];
  assign wr_take = avs_write && !waitreq_r && avs_byteenable[0];
  assign rd_take = avs_read && waitreq_r;

  always_comb
  begin
    unique case (reg_idx)
      IDX_CONFIG:     rd_byte = config_r;
      IDX_STATUS:     rd_byte = {3'h0, pulsed_r, s5_wake_r, state_r};
      IDX_WAKE_DELAY: rd_byte = wake_delay_r;
      IDX_WAKE_WIDTH: rd_byte = wake_width_r;
      IDX_ENTRY_DLY:  rd_byte = entry_dly_r;
      default:        rd_byte = 8'h00;
    endcase
  end

  // Waitrequest handshake, one wait cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      waitreq_r <= 1'b1;
    else if ((avs_read || avs_write) && waitreq_r)
      waitreq_r <= 1'b0;
    else
      waitreq_r <= 1'b1;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      readdata_r <= 32'h0;
    else if (rd_take)
      readdata_r <= {24'h0, rd_byte};
  end

  // Battery-domain registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      config_r    <= RST_CONFIG; // RULE_14
      entry_dly_r <= RST_ENTRY_DLY;
    end
    else if (wr_take)
    begin
      if (reg_idx == IDX_CONFIG)
        config_r <= (avs_writedata[7:0] & MSK_CONFIG) | (RST_CONFIG & ~MSK_CONFIG);
      if (reg_idx == IDX_ENTRY_DLY)
        entry_dly_r <= avs_writedata[7:0] & MSK_ENTRY_DLY;
    end
  end

  // Wake timing registers, reloaded while resume reset is asserted
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wake_delay_r <= RST_WAKE_DELAY;
      wake_width_r <= RST_WAKE_WIDTH;
    end
    else if (!rr_n_r)
    begin
      wake_delay_r <= RST_WAKE_DELAY;
      wake_width_r <= RST_WAKE_WIDTH;
    end
    else if (wr_take)
    begin
      if (reg_idx == IDX_WAKE_DELAY)
        wake_delay_r <= avs_writedata[7:0] & MSK_WAKE_DELAY;
      if (reg_idx == IDX_WAKE_WIDTH)
        wake_width_r <= avs_writedata[7:0] & MSK_WAKE_WIDTH;
    end
  end

  // Sequencer conditions
  assign enter_s5 = !s5_n_s && config_r[CFG_DEEP_S5]; // RULE_01
  assign enter_s3 = !s3_n_s && config_r[CFG_DEEP_S3]; // RULE_02
  assign opt_on   = config_r[CFG_WAKE_OPT] && config_r[CFG_DEEP_WELL]
                    && (config_r[CFG_DEEP_S5] || config_r[CFG_DEEP_S3]); // RULE_05
  assign hold_done = opt_on ? (rr_n_r && sus_n_s) : s3_n_s; // RULE_04

  // Counter load and pacing
  always_comb
  begin
    cnt_load  = 1'b0;
    cnt_value = '0;
    cnt_tick  = tick.ms_tick; // RULE_15
    unique case (state_r)
      DSQ_RUN:
      begin
        cnt_load  = enter_s5 || enter_s3;
        cnt_value = CNT_W'(entry_dly_r[ENTRY_CNT_MSB:0]); // RULE_12
      end
      DSQ_ENTRY_WAIT:
        cnt_tick = entry_dly_r[ENTRY_UNIT] ? tick.min_tick : tick.sec_tick; // RULE_13
      DSQ_WAKE_RAIL:
      begin
        cnt_load  = rail_s;
        cnt_value = CNT_W'(wake_delay_r[WAKE_DLY_MSB:0] * WAKE_DLY_MS); // RULE_10
      end
      DSQ_WAKE_DELAY:
      begin
        cnt_load  = cnt_done;
        cnt_value = CNT_W'(wake_width_r[WIDTH_MSB:0] * PULSE_MS); // RULE_11
      end
      default:
        cnt_load = 1'b0;
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      state_r <= DSQ_RUN;
    else
    begin
      unique case (state_r)
        DSQ_RUN:
          if (enter_s5 || enter_s3)
            state_r <= DSQ_ENTRY_WAIT;
        DSQ_ENTRY_WAIT:
          if (s3_n_s)
            state_r <= DSQ_RUN;
          else if (cnt_done)
            state_r <= DSQ_DEEP; // RULE_12
        DSQ_DEEP:
          if (wake_s)
            state_r <= DSQ_WAKE_RAIL;
        DSQ_WAKE_RAIL:
          if (rail_s)
            state_r <= DSQ_WAKE_DELAY; // RULE_09
        DSQ_WAKE_DELAY:
          if (cnt_done)
            state_r <= DSQ_WAKE_PULSE; // RULE_09
        DSQ_WAKE_PULSE:
          if (cnt_done)
            state_r <= s5_wake_r ? DSQ_WAKE_HOLD : DSQ_RUN;
        DSQ_WAKE_HOLD:
          if (hold_done)
            state_r <= DSQ_RUN; // RULE_04
        default:
          state_r <= DSQ_RUN;
      endcase
    end
  end

  // Remember whether deep sleep came from S5
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      s5_wake_r <= 1'b0;
    else if (state_r == DSQ_ENTRY_WAIT && cnt_done)
      s5_wake_r <= !s5_n_s && config_r[CFG_DEEP_S5];
  end

  // Power switch low pulse
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      psw_n_r <= 1'b1;
    else if (state_r == DSQ_WAKE_DELAY && cnt_done)
      psw_n_r <= 1'b0; // RULE_09
    else if (state_r == DSQ_WAKE_PULSE && cnt_done && !s5_wake_r)
      psw_n_r <= 1'b1; // RULE_11
    else if (state_r == DSQ_WAKE_HOLD && hold_done)
      psw_n_r <= 1'b1; // RULE_04
  end

  // Power switch has been seen low during this wake
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      pulsed_r <= 1'b0;
    else if (state_r == DSQ_DEEP)
      pulsed_r <= 1'b0;
    else if (!psw_n_r)
      pulsed_r <= 1'b1;
  end

  // Resume reset release source
  assign rr_release = !config_r[CFG_RR_SRC] && pulsed_r; // RULE_06

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rr_n_r <= 1'b1;
    else if (config_r[CFG_DEEP_WELL] && !sus_n_s)
      rr_n_r <= 1'b0; // RULE_03
    else if (state_r == DSQ_DEEP)
      rr_n_r <= 1'b0;
    else if (state_r != DSQ_RUN && state_r != DSQ_ENTRY_WAIT && rr_release)
      rr_n_r <= 1'b1; // RULE_06
    else if (state_r == DSQ_RUN && !config_r[CFG_DEEP_WELL])
      rr_n_r <= 1'b1;
    else if (state_r == DSQ_RUN && sus_n_s)
      rr_n_r <= 1'b1; // RULE_03
  end

  // Pin-level outputs
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pu_en_r <= 1'b1;
      deep_r  <= 1'b0;
    end
    else
    begin
      pu_en_r <= !config_r[CFG_PU_DIS]; // RULE_08
      deep_r  <= (state_r == DSQ_DEEP);
    end
  end

  assign avs_readdata       = readdata_r;
  assign avs_waitrequest    = waitreq_r;
  assign power_switch_out_n = psw_n_r;
  assign resume_reset_n     = rr_n_r;
  assign suspend_pullup_en  = pu_en_r;
  assign deep_sleep_active  = deep_r;

endmodule : dsq_top

/* File: verif/dsq_top_sva.sv */
// Port checker for the deep sleep sequencer
`timescale 1ns/100ps
module dsq_top_sva
  import dsq_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = MS_CYCLES
)(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        sleep_s3_n,
  input wire logic        sleep_s5_n,
  input wire logic        suspend_sleep_n,
  input wire logic        standby_rail_good,
  input wire logic        wake_event,
  input wire logic        power_switch_out_n,
  input wire logic        resume_reset_n,
  input wire logic        suspend_pullup_en,
  input wire logic        deep_sleep_active
);
  logic [7:0] cfg_r;

  // Shadow of the configuration register
  always_ff @(posedge clk or posedge reset)
    if (reset)
      cfg_r <= RST_CONFIG;
    else if (avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address[9:2] == IDX_CONFIG)
      cfg_r <= (avs_writedata[7:0] & MSK_CONFIG) | RST_CONFIG;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_req_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_susp_low;
    (cfg_r[3] && !suspend_sleep_n) [*5];
  endsequence
  sequence s_s5_held;
    (cfg_r[0] && !cfg_r[1] && !(cfg_r[4] && cfg_r[3]) && !power_switch_out_n && !sleep_s3_n) [*4];
  endsequence

  a_bus_answer: assert property (s_req_taken |=> !avs_waitrequest)
    else $error("request not answered");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_cfg_readback: assert property (
    s_req_taken ##0 (avs_read && avs_address[9:2] == IDX_CONFIG) |=> avs_readdata[7:0] == cfg_r)
    else $error("configuration readback wrong");
  a_s5_entry_gate: assert property (
    $rose(deep_sleep_active) && !cfg_r[1] |-> cfg_r[0] && !sleep_s5_n)
    else $error("deep entry without S5 enable");
  a_s3_entry_gate: assert property (
    $rose(deep_sleep_active) && sleep_s5_n |-> cfg_r[1] && !sleep_s3_n)
    else $error("deep entry without S3 enable");
  a_susp_resume: assert property (s_susp_low |-> !resume_reset_n)
    else $error("suspend sleep did not hold resume reset");
  a_pullup_cfg: assert property ($stable(cfg_r[7]) |-> suspend_pullup_en == !cfg_r[7])
    else $error("pull-up enable wrong");
  a_switch_rail: assert property (
    $fell(power_switch_out_n) |-> standby_rail_good && $past(standby_rail_good, 4))
    else $error("power switch pulse before rail good");
  a_s5_hold: assert property (s_s5_held |=> !power_switch_out_n)
    else $error("power switch released before S3 exit");
  a_deep_resume: assert property (deep_sleep_active |-> !resume_reset_n)
    else $error("resume reset high in deep state");
endmodule : dsq_top_sva

bind dsq_top dsq_top_sva #(.CYC_PER_MS(CYC_PER_MS)) u_sva (.*);

/* File: verif/dsq_platform_model.sv */
// Platform chipset model for sleep, rail and wake pins
`timescale 1ns/100ps
module dsq_platform_model #(
  parameter int unsigned RAIL_DLY = 40,
  parameter int unsigned RESP_DLY = 2000
)(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [2:0] cmd,
  input  wire logic       susp_low,
  input  wire logic       power_switch_out_n,
  output logic            sleep_s3_n,
  output logic            sleep_s5_n,
  output logic            suspend_sleep_n,
  output logic            standby_rail_good,
  output logic            wake_event
);
  logic        s3_r, s5_r, woke_r, sw_r;
  int unsigned cnt_r, resp_r;

  // Sleep state; back to S0 on command or after answering the switch
  always_ff @(posedge clk or posedge reset)
    if (reset || cmd == 3'h3 || resp_r == RESP_DLY)
      {s3_r, s5_r, woke_r, sw_r} <= 4'h0;
    else
    begin
      s3_r   <= s3_r | cmd == 3'h1 | cmd == 3'h2;
      s5_r   <= s5_r | cmd == 3'h2;
      woke_r <= woke_r | cmd == 3'h4;
      sw_r   <= sw_r | (woke_r & ~power_switch_out_n);
    end

  // Rail ramp and switch answer times
  always_ff @(posedge clk)
  begin
    cnt_r  <= woke_r ? cnt_r + 1 : 0;
    resp_r <= sw_r ? resp_r + 1 : 0;
  end

  assign sleep_s3_n        = ~s3_r;
  assign sleep_s5_n        = ~s5_r;
  assign suspend_sleep_n   = ~susp_low;
  assign standby_rail_good = ~s3_r | (cnt_r >= RAIL_DLY);
  assign wake_event        = woke_r & ~sw_r;
endmodule : dsq_platform_model

/* File: verif/testbench.sv */
// Self-checking testbench for the deep sleep sequencer
`timescale 1ns/100ps
module testbench
  import dsq_pkg::*;
;
  localparam int unsigned MS   = 10;
  localparam int unsigned RESP = 2000;

  logic        clk = 1'h0;
  logic        reset;
  logic [9:0]  avs_address = 10'h0;
  logic        avs_read = 1'h0, avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [2:0]  cmd = 3'h0;
  logic        susp_low = 1'h0;
  logic        sleep_s3_n, sleep_s5_n, suspend_sleep_n, standby_rail_good, wake_event;
  logic        power_switch_out_n, resume_reset_n, suspend_pullup_en, deep_sleep_active;
  int          bad_count = 0, cmp_count = 0;

  dsq_top #(.CYC_PER_MS(MS)) u_dut (.*);
  dsq_platform_model #(.RESP_DLY(RESP)) u_plat (.*);

  always #2 clk = ~clk;

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic hang();
    bad_count++;
    finish_test();
  endtask : hang

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= {idx, 2'h0};
    avs_writedata <= {24'h0, wd};
    avs_read      <= ~wr;
    avs_write     <= wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'h0 && n < 50);
    rd = avs_readdata;
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
    if (n >= 50)
      hang();
  endtask : bus

  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] rd;
    bus(1'h1, idx, wd, rd);
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] rd;
    bus(1'h0, idx, 8'h00, rd);
    check($sformatf("register %h", idx), rd, {24'h0, exp});
  endtask : rd_chk

  task automatic plat(input logic [2:0] c);
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    cmd <= 3'h0;
  endtask : plat

  // Pin 0 deep state, 1 power switch, 2 rail good
  task automatic wait_for(input int sel, input logic lvl, input int lim, output int cyc);
    logic [2:0] p;
    cyc = 0;
    p = {standby_rail_good, power_switch_out_n, deep_sleep_active};
    while (p[sel] !== lvl && cyc < lim)
    begin
      @(posedge clk);
      cyc++;
      p = {standby_rail_good, power_switch_out_n, deep_sleep_active};
    end
    if (cyc >= lim)
      hang();
  endtask : wait_for

  task automatic t_regs();
    logic [7:0] ri [4];
    logic [7:0] rv [4];
    logic [7:0] mk [4];
    ri = '{IDX_CONFIG, IDX_WAKE_DELAY, IDX_WAKE_WIDTH, IDX_ENTRY_DLY};
    rv = '{RST_CONFIG, RST_WAKE_DELAY, RST_WAKE_WIDTH, RST_ENTRY_DLY};
    mk = '{MSK_CONFIG, MSK_WAKE_DELAY, MSK_WAKE_WIDTH, MSK_ENTRY_DLY};
    check("pull-up enable", suspend_pullup_en, 1);
    for (int i = 0; i < 4; i++)
    begin
      rd_chk(ri[i], rv[i]);
      wr_reg(ri[i], 8'hff);
      rd_chk(ri[i], mk[i] | rv[i]);
    end
    repeat (2) @(posedge clk);
    check("pull-up enable", suspend_pullup_en, 0);
    wr_reg(8'h00, 8'h5a);
    rd_chk(8'h00, 8'h00);
    wr_reg(IDX_CONFIG, 8'h00);
    repeat (2) @(posedge clk);
    check("pull-up enable", suspend_pullup_en, 1);
  endtask : t_regs

  task automatic t_susp();
    wr_reg(IDX_CONFIG, 8'h48);
    susp_low <= 1'h1;
    repeat (8) @(posedge clk);
    check("resume reset", resume_reset_n, 0);
    wr_reg(IDX_CONFIG, 8'h00);
    repeat (8) @(posedge clk);
    check("resume reset", resume_reset_n, 1);
    susp_low <= 1'h0;
  endtask : t_susp

  task automatic t_off();
    plat(3'h2);
    repeat (100) @(posedge clk);
    check("deep state", deep_sleep_active, 0);
    plat(3'h3);
  endtask : t_off

  task automatic t_s3();
    int c;
    wr_reg(IDX_ENTRY_DLY, 8'h02);
    wr_reg(IDX_CONFIG, 8'h02);
    plat(3'h1);
    wait_for(0, 1'h1, 30000, c);
    check("entry delay", c >= 1000 * MS - 5 && c <= 2000 * MS + 10, 1);
    check("resume reset", resume_reset_n, 0);
    plat(3'h4);
    wait_for(2, 1'h1, 200, c);
    wait_for(1, 1'h0, 6000, c);
    c -= RST_WAKE_DELAY * WAKE_DLY_MS * MS;
    check("wake delay", c >= -10 && c <= 8, 1);
    wait_for(1, 1'h1, 3000, c);
    c -= RST_WAKE_WIDTH * PULSE_MS * MS;
    check("pulse width", c >= -10 && c <= 4, 1);
    check("resume reset", resume_reset_n, 1);
    repeat (1000) @(posedge clk);
  endtask : t_s3

  task automatic t_s5();
    int c;
    wr_reg(IDX_CONFIG, 8'h01);
    plat(3'h2);
    wait_for(0, 1'h1, 30000, c);
    plat(3'h4);
    wait_for(1, 1'h0, 6000, c);
    wait_for(1, 1'h1, 3000, c);
    check("switch hold", c >= RESP && c <= RESP + 12, 1);
  endtask : t_s5

  task automatic t_minute();
    wr_reg(IDX_ENTRY_DLY, 8'h81);
    wr_reg(IDX_CONFIG, 8'h02);
    plat(3'h1);
    repeat (12000) @(posedge clk);
    check("minute unit", deep_sleep_active, 1'h0);
    plat(3'h3);
    repeat (10) @(posedge clk);
  endtask : t_minute

  task automatic t_s5_opt();
    int c;
    wr_reg(IDX_ENTRY_DLY, 8'h01);
    wr_reg(IDX_CONFIG, 8'h19);
    plat(3'h2);
    wait_for(0, 1'h1, 30000, c);
    plat(3'h4);
    wait_for(1, 1'h0, 6000, c);
    wait_for(1, 1'h1, 3000, c);
    c -= RST_WAKE_WIDTH * PULSE_MS * MS;
    check("option release", c >= -8 && c <= 4, 1);
  endtask : t_s5_opt

  initial
  begin
    reset = 1'h1;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    t_regs();
    t_susp();
    t_off();
    t_minute();
    t_s3();
    t_s5();
    t_s5_opt();
    finish_test();
  end
endmodule : testbench
